// file: src/hda_alarm_regs.sv
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "hda_params.svh"
// Functional notes
// RQ1: hour enable bit 7, active low, resets 1
// RQ2: 24h mode, bits 5:0 BCD hour
// RQ3: 12h mode, bits 4:0 hour, bit 5 PM
// RQ4: unused alarm bits always read zero
// RQ5: alarms readable, writes blocked when protected
// RQ6: day select bit picks weekday or date
// RQ7: weekday mode holds bits 2:0
// RQ8: date mode holds BCD bits 5:0
// RQ9: software must load a valid date
// RQ10: day enable bit 7 joins matching
// RQ11: day register resets to 80h
// RQ12: date matching valid through leap years
// RQ13: minute enable bit 7, resets 1
// RQ14: alarm when all enabled fields match
module hda_alarm_regs
    import hda_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // protection and time from the core
    input wire logic writeLocked,
    input wire hda_time_s curTime,
    input wire logic curPm,
    // interrupt and status
    output logic alarmIrq,
    output logic alarmMatch
);
    hda_cmp_if cmpBus();
    logic [7:0] minuteAlarm;
    logic [7:0] hourAlarm;
    logic [7:0] dayAlarm;
    logic daySel;
    logic fmt12;
    logic irqStat;
    logic irqMask;
    logic matchSeen;
    logic [7:0] next_rdata;
    logic wrOk;

    // protection only gates writes to alarm fields and mode bits, reads stay open
    assign wrOk = regWr && !writeLocked; // RQ5

    // alarm registers; bit 6 of hour and day stored as zero so it reads zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            minuteAlarm <= `HDA_MIN_ALARM_RST; // RQ13
            hourAlarm <= `HDA_HOUR_ALARM_RST; // RQ1
            dayAlarm <= `HDA_DAY_ALARM_RST; // RQ11
        end else if (wrOk) begin
            if (regAddr == `HDA_MIN_ALARM_ADDR) begin
                minuteAlarm <= regWdata;
            end
            if (regAddr == `HDA_HOUR_ALARM_ADDR) begin
                hourAlarm <= {regWdata[7], 1'b0, regWdata[5:0]}; // RQ4
            end
            if (regAddr == `HDA_DAY_ALARM_ADDR) begin
                dayAlarm <= {regWdata[7], 1'b0, regWdata[5:0]}; // RQ4
            end
        end
    end

    // mode bits share the protection of the alarm registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            daySel <= 1'b0;
            fmt12 <= 1'b0;
        end else if (wrOk) begin
            if (regAddr == `HDA_DAYSEL_ADDR) begin
                daySel <= regWdata[`HDA_DAYSEL_BIT]; // RQ6
            end
            if (regAddr == `HDA_CTRL_ADDR) begin
                fmt12 <= regWdata[`HDA_FMT12_BIT];
            end
        end
    end

    assign cmpBus.minuteAlarm = minuteAlarm;
    assign cmpBus.hourAlarm = hourAlarm;
    assign cmpBus.dayAlarm = dayAlarm;
    assign cmpBus.fmt12 = fmt12;
    assign cmpBus.daySel = daySel;

    // leap years need no work here: day and date come from the core
    hda_match uMatch (
        .cmp(cmpBus.cmp),
        .now(curTime),
        .nowPm(curPm)
    ); // RQ12

    // edge of the match sets the sticky flag; set beats a clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            matchSeen <= 1'b0;
            irqStat <= 1'b0;
        end else begin
            matchSeen <= cmpBus.match;
            if (cmpBus.match && !matchSeen) begin
                irqStat <= 1'b1; // RQ14
            end else if (regWr && regAddr == `HDA_IRQ_STAT_ADDR &&
                regWdata[0]) begin
                irqStat <= 1'b0;
            end
        end
    end

    // interrupt mask, not covered by write protection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqMask <= 1'b0;
        end else if (regWr && regAddr == `HDA_IRQ_MASK_ADDR) begin
            irqMask <= regWdata[0];
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarmIrq <= 1'b0;
            alarmMatch <= 1'b0;
        end else begin
            alarmIrq <= irqMask && (irqStat ||
                (cmpBus.match && !matchSeen));
            alarmMatch <= cmpBus.match;
        end
    end

    // read mux; day register hides bits 6:3 in weekday mode
    always_comb begin
        next_rdata = 8'h00;
        unique case (regAddr)
            `HDA_MIN_ALARM_ADDR: next_rdata = minuteAlarm;
            `HDA_HOUR_ALARM_ADDR: next_rdata = hourAlarm;
            `HDA_DAY_ALARM_ADDR: begin
                if (daySel) begin
                    next_rdata = dayAlarm;
                end else begin
                    next_rdata = {dayAlarm[7], 4'h0, dayAlarm[2:0]}; // RQ4
                end
            end
            `HDA_DAYSEL_ADDR: next_rdata = {2'h0, daySel, 5'h00};
            `HDA_CTRL_ADDR: next_rdata = {6'h00, fmt12, 1'b0};
            `HDA_IRQ_STAT_ADDR: next_rdata = {7'h00, irqStat};
            `HDA_IRQ_MASK_ADDR: next_rdata = {7'h00, irqMask};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            regRdata <= next_rdata; // RQ5
        end else begin
            regRdata <= 8'h00;
        end
    end

    // checks
    a_hour_reset: assert property (@(posedge sys_clk)
        $fell(rst) |-> hourAlarm == 8'h80) // RQ1
        else $error("hour alarm reset wrong");
    a_day_reset: assert property (@(posedge sys_clk)
        $fell(rst) |-> dayAlarm == 8'h80) // RQ11
        else $error("day alarm reset wrong");
    a_min_reset: assert property (@(posedge sys_clk)
        $fell(rst) |-> minuteAlarm[7]) // RQ13
        else $error("minute enable reset wrong");
    a_hour_bit6: assert property (@(posedge sys_clk) disable iff (rst)
        regRd && regAddr == 8'h08 |=> !regRdata[6]) // RQ4
        else $error("hour bit 6 not zero");
    a_weekday_zero: assert property (@(posedge sys_clk) disable iff (rst)
        regRd && regAddr == 8'h09 && !daySel |=> regRdata[6:3] == 4'h0)
        else $error("weekday unused bits set"); // RQ4
    a_lock_blocks: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && writeLocked && regAddr == 8'h08 |=> $stable(hourAlarm))
        else $error("locked write changed alarm"); // RQ5
    a_day_write: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && !writeLocked && regAddr == 8'h09 |=>
        dayAlarm[5:0] == $past(regWdata[5:0])) // RQ8
        else $error("day alarm write lost");
    a_hour_disable: assert property (@(posedge sys_clk) disable iff (rst)
        hourAlarm[7] && dayAlarm[7] && minuteAlarm[7] |=> !alarmMatch)
        else $error("match with all fields off"); // RQ10
    a_match_12h: assert property (@(posedge sys_clk) disable iff (rst)
        fmt12 && !hourAlarm[7] && hourAlarm[5] != curPm |=> !alarmMatch)
        else $error("meridiem ignored"); // RQ3
    a_irq_set: assert property (@(posedge sys_clk) disable iff (rst)
        cmpBus.match && !matchSeen |=> irqStat) // RQ14
        else $error("match did not set flag");
    c_irq_fire: cover property (@(posedge sys_clk) alarmIrq);
    c_date_match: cover property (@(posedge sys_clk)
        daySel && !dayAlarm[7] && alarmMatch);
    c_locked_write: cover property (@(posedge sys_clk)
        regWr && writeLocked);
    c_weekday_match: cover property (@(posedge sys_clk)
        !daySel && !dayAlarm[7] && alarmMatch);
    c_stat_clear: cover property (@(posedge sys_clk)
        regWr && regAddr == 8'h20 && irqStat);

    // date mode still keeps bit 6 clear on read
    a_date_bit6: assert property (@(posedge sys_clk) disable iff (rst)
        regRd && regAddr == 8'h09 && daySel |=> !regRdata[6]) // RQ4
        else $error("date bit 6 not zero");
    // bit 6 is never stored, so no later mode can expose it
    a_hour_store6: assert property (@(posedge sys_clk) disable iff (rst)
        !hourAlarm[6]) // RQ4
        else $error("hour bit 6 stored");
    // same for the day register
    a_day_store6: assert property (@(posedge sys_clk) disable iff (rst)
        !dayAlarm[6]) // RQ4
        else $error("day bit 6 stored");
    // hour value lands whole on an open write
    a_hour_write: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && !writeLocked && regAddr == 8'h08 |=>
        hourAlarm[5:0] == $past(regWdata[5:0])) // RQ2
        else $error("hour alarm write lost");
    // hour enable follows the written bit 7
    a_hour_en_write: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && !writeLocked && regAddr == 8'h08 |=>
        hourAlarm[7] == $past(regWdata[7])) // RQ1
        else $error("hour enable write lost");
    // day enable follows the written bit 7
    a_day_en_write: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && !writeLocked && regAddr == 8'h09 |=>
        dayAlarm[7] == $past(regWdata[7])) // RQ10
        else $error("day enable write lost");
    // minute register takes the full byte
    a_min_write: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && !writeLocked && regAddr == 8'h07 |=>
        minuteAlarm == $past(regWdata)) // RQ13
        else $error("minute alarm write lost");
    // protection also covers the day register
    a_lock_day: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && writeLocked && regAddr == 8'h09 |=> $stable(dayAlarm))
        else $error("locked write changed day"); // RQ5
    // and the minute register
    a_lock_min: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && writeLocked && regAddr == 8'h07 |=>
        $stable(minuteAlarm)) // RQ5
        else $error("locked write changed minute");
    // mode bit cannot be flipped behind the lock
    a_lock_sel: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && writeLocked && regAddr == 8'h0F |=> $stable(daySel))
        else $error("locked write changed day select"); // RQ6
    // open write of the select register sets the day mode
    a_sel_write: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && !writeLocked && regAddr == 8'h0F |=>
        daySel == $past(regWdata[5])) // RQ6
        else $error("day select write lost");
    // format bit follows its write
    a_fmt_write: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && !writeLocked && regAddr == 8'h10 |=>
        fmt12 == $past(regWdata[1])) // RQ3
        else $error("format write lost");
    // hour register reads back what is stored
    a_hour_read: assert property (@(posedge sys_clk) disable iff (rst)
        regRd && regAddr == 8'h08 |=> regRdata == $past(hourAlarm))
        else $error("hour read wrong"); // RQ5
    // date mode shows the full stored day byte
    a_day_read: assert property (@(posedge sys_clk) disable iff (rst)
        regRd && regAddr == 8'h09 && daySel |=>
        regRdata == $past(dayAlarm)) // RQ8
        else $error("date read wrong");
    // weekday mode shows the low three bits
    a_weekday_read: assert property (@(posedge sys_clk) disable iff (rst)
        regRd && regAddr == 8'h09 && !daySel |=>
        regRdata[2:0] == $past(dayAlarm[2:0])) // RQ7
        else $error("weekday read wrong");
    // read data is zero outside the answer cycle
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !regRd |=> regRdata == 8'h00) // RQ5
        else $error("read data left standing");
    // a wrong hour in 24h mode blocks the match
    a_match_24h: assert property (@(posedge sys_clk) disable iff (rst)
        !fmt12 && !hourAlarm[7] && hourAlarm[5:0] != curTime.hour |=>
        !alarmMatch) // RQ2
        else $error("24h hour mismatch ignored");
    // a wrong date blocks the match
    a_match_date: assert property (@(posedge sys_clk) disable iff (rst)
        daySel && !dayAlarm[7] && dayAlarm[5:0] != curTime.day |=>
        !alarmMatch) // RQ8
        else $error("date mismatch ignored");
    // a wrong weekday blocks the match
    a_match_weekday: assert property (@(posedge sys_clk) disable iff (rst)
        !daySel && !dayAlarm[7] && dayAlarm[2:0] != curTime.weekday |=>
        !alarmMatch) // RQ7
        else $error("weekday mismatch ignored");
    // a wrong minute blocks the match
    a_match_min: assert property (@(posedge sys_clk) disable iff (rst)
        !minuteAlarm[7] && minuteAlarm[6:0] != curTime.minute |=>
        !alarmMatch) // RQ13
        else $error("minute mismatch ignored");
    // in 24h weekday mode every field enabled and equal must give a match
    a_match_all: assert property (@(posedge sys_clk) disable iff (rst)
        !fmt12 && !daySel && !hourAlarm[7] && !dayAlarm[7] &&
        !minuteAlarm[7] && hourAlarm[5:0] == curTime.hour &&
        dayAlarm[2:0] == curTime.weekday &&
        minuteAlarm[6:0] == curTime.minute |=> alarmMatch) // RQ14
        else $error("full match missed");
    // mask off keeps the pin low
    a_irq_masked: assert property (@(posedge sys_clk) disable iff (rst)
        !irqMask |=> !alarmIrq) // RQ14
        else $error("masked interrupt raised");
    // unmasked sticky flag drives the pin
    a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
        irqMask && irqStat |=> alarmIrq) // RQ14
        else $error("interrupt missing");
    // a one written clears the flag unless a new edge arrives
    a_stat_clear: assert property (@(posedge sys_clk) disable iff (rst)
        regWr && regAddr == 8'h20 && regWdata[0] &&
        !(cmpBus.match && !matchSeen) |=> !irqStat) // RQ14
        else $error("status not cleared");
    // flag stays until software clears it
    a_stat_hold: assert property (@(posedge sys_clk) disable iff (rst)
        irqStat && !(regWr && regAddr == 8'h20 && regWdata[0]) |=>
        irqStat) // RQ14
        else $error("status dropped by itself");
endmodule

// file: src/hda_params.svh
`ifndef HDA_PARAMS_SVH
`define HDA_PARAMS_SVH
// register byte addresses
`define HDA_MIN_ALARM_ADDR 8'h07
`define HDA_HOUR_ALARM_ADDR 8'h08
`define HDA_DAY_ALARM_ADDR 8'h09
`define HDA_DAYSEL_ADDR 8'h0F
`define HDA_CTRL_ADDR 8'h10
`define HDA_IRQ_STAT_ADDR 8'h20
`define HDA_IRQ_MASK_ADDR 8'h21
// field positions
`define HDA_ENABLE_BIT 7
`define HDA_DAYSEL_BIT 5
`define HDA_FMT12_BIT 1
`define HDA_MERIDIEM_BIT 5
// reset values
`define HDA_MIN_ALARM_RST 8'h80
`define HDA_HOUR_ALARM_RST 8'h80
`define HDA_DAY_ALARM_RST 8'h80
`endif

// file: src/hda_pkg.sv
package hda_pkg;
    typedef logic [7:0] hda_byte_t;
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [5:0] day;
        logic [2:0] weekday;
    } hda_time_s;
endpackage

// file: src/hda_cmp_if.sv
`timescale 1ns/100ps
// alarm fields travelling to the comparator
interface hda_cmp_if;
    logic [7:0] minuteAlarm;
    logic [7:0] hourAlarm;
    logic [7:0] dayAlarm;
    logic fmt12;
    logic daySel;
    logic match;
    modport regs (output minuteAlarm, hourAlarm, dayAlarm, fmt12, daySel,
        input match);
    modport cmp (input minuteAlarm, hourAlarm, dayAlarm, fmt12, daySel,
        output match);
endinterface

// file: src/hda_match.sv
`timescale 1ns/100ps
`include "hda_params.svh"
module hda_match
    import hda_pkg::*;
(
    // fields from the register file
    hda_cmp_if.cmp cmp,
    // current time from the clock core
    input wire hda_time_s now,
    input wire logic nowPm
);
    logic hourHit;
    logic dayHit;
    logic minHit;

    // disabled fields count as a hit; formats decide compared width
    always_comb begin
        minHit = cmp.minuteAlarm[`HDA_ENABLE_BIT] ||
            (cmp.minuteAlarm[6:0] == now.minute);
        if (cmp.fmt12) begin // RQ3
            hourHit = (cmp.hourAlarm[4:0] == now.hour[4:0]) &&
                (cmp.hourAlarm[`HDA_MERIDIEM_BIT] == nowPm);
        end else begin // RQ2
            hourHit = (cmp.hourAlarm[5:0] == now.hour);
        end
        hourHit = hourHit || cmp.hourAlarm[`HDA_ENABLE_BIT]; // RQ1
        if (cmp.daySel) begin // RQ8
            dayHit = (cmp.dayAlarm[5:0] == now.day);
        end else begin // RQ7
            dayHit = (cmp.dayAlarm[2:0] == now.weekday);
        end
        dayHit = dayHit || cmp.dayAlarm[`HDA_ENABLE_BIT]; // RQ10
    end

    // nothing enabled means no alarm at all
    assign cmp.match = minHit && hourHit && dayHit && // RQ14
        !(cmp.minuteAlarm[7] && cmp.hourAlarm[7] && cmp.dayAlarm[7]);
endmodule

// file: test/hour_and_day_alarm_registers_test.sv
`timescale 1ns/100ps
`include "hda_params.svh"
module hour_and_day_alarm_registers_test
    import hda_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic writeLocked = 1'b0;
    logic curPm = 1'b0;
    hda_time_s curTime = '0;
    logic [7:0] regRdata;
    logic alarmIrq;
    logic alarmMatch;
    int nErrors = 0;
    int nChecks = 0;

    // 50 ns period
    always #25 sys_clk = ~sys_clk;

    hda_alarm_regs u_dut (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .writeLocked(writeLocked),
        .curTime(curTime), .curPm(curPm), .alarmIrq(alarmIrq),
        .alarmMatch(alarmMatch)
    );

    // byte compare, flags are zero extended
    task chk(string nm, logic [7:0] e, logic [7:0] g);
        nChecks++;
        if (g !== e) begin
            nErrors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task rd(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, regRdata);
    endtask

    // irq is registered, so give it two edges to land
    task irq(logic e);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq", {7'h00, e}, {7'h00, alarmIrq});
    endtask

    // present a time and check the combined match a few cycles on
    task tm(logic [6:0] m, logic [5:0] h, logic [5:0] d, logic [2:0] w,
            logic pm, logic e);
        @(posedge sys_clk);
        curTime <= '{m, h, d, w};
        curPm <= pm;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("match", {7'h00, e}, {7'h00, alarmMatch});
    endtask

    task complete_run;
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // cuts a hang short; tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        nErrors++;
        complete_run;
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h07, 8'h80);
        rd(8'h08, 8'h80);
        rd(8'h09, 8'h80);
        rd(8'h0F, 8'h00);
        rd(8'h20, 8'h00);
        $display("test reset done");
        wr(8'h08, 8'hFF);
        rd(8'h08, 8'hBF);
        wr(8'h09, 8'hFF);
        rd(8'h09, 8'h87);
        wr(8'h0F, 8'h20);
        rd(8'h09, 8'hBF);
        rd(8'h30, 8'h00);
        $display("test fields done");
        @(posedge sys_clk);
        writeLocked <= 1'b1;
        wr(8'h08, 8'h12);
        wr(8'h0F, 8'h00);
        rd(8'h08, 8'hBF);
        rd(8'h0F, 8'h20);
        @(posedge sys_clk);
        writeLocked <= 1'b0;
        $display("test lock done");
        wr(8'h0F, 8'h00);
        wr(8'h07, 8'h30);
        wr(8'h08, 8'h23);
        wr(8'h09, 8'h80);
        tm(7'h30, 6'h23, 6'h00, 3'h0, 1'b0, 1'b1);
        irq(1'b0);
        rd(8'h20, 8'h01);
        wr(8'h21, 8'h01);
        irq(1'b1);
        wr(8'h20, 8'h01);
        irq(1'b0);
        tm(7'h31, 6'h23, 6'h00, 3'h0, 1'b0, 1'b0);
        $display("test irq done");
        wr(8'h09, 8'h05);
        tm(7'h30, 6'h23, 6'h00, 3'h5, 1'b0, 1'b1);
        tm(7'h30, 6'h23, 6'h00, 3'h4, 1'b0, 1'b0);
        wr(8'h0F, 8'h20);
        wr(8'h09, 8'h29);
        tm(7'h30, 6'h23, 6'h29, 3'h0, 1'b0, 1'b1);
        tm(7'h30, 6'h23, 6'h28, 3'h0, 1'b0, 1'b0);
        $display("test day done");
        wr(8'h10, 8'h02);
        wr(8'h08, 8'h31);
        wr(8'h09, 8'h80);
        tm(7'h30, 6'h11, 6'h00, 3'h0, 1'b1, 1'b1);
        tm(7'h30, 6'h11, 6'h00, 3'h0, 1'b0, 1'b0);
        $display("test meridiem done");
        complete_run;
    end
endmodule
